// ---- rtl/fai_irq_core.sv ----
/*
   Fault and event masking core: alarm and general mask registers, alarm and
   general status with summary bits, the interrupt and the active-low alarm.
   Assumes the register port and the counter inputs share ref_clk_i; the
   monitor fault levels and general events may come from anywhere.
*/
// Notes on behaviour
// RL1 - Self-diag mask clear lets fault interrupt
// RL2 - Status bits set regardless of masks
// RL3 - Oscillator and reference masks reset unmasked
// RL4 - Other alarm masks reset to masked
// RL5 - Slew-idle mask gates interrupt, resets masked
// RL6 - Remaining general masks reset to one
// RL7 - Alarm status bit 15 ORs unmasked general
// RL8 - Bit 13 shows any self-diag failure
// RL9 - Unmasked oscillator fault holds alarm, never interrupts
// RL10 - Bits 11-10 show crc counter by limit
// RL11 - Nvm-not-loaded resets set, holds alarm
// RL12 - Nvm crc error is a maskable fault
// RL13 - Latched faults clear on read unless present
// RL14 - General status bit 15 ORs unmasked alarms other than oscillator
// RL15 - Mask writes act from next cycle
module fai_irq_core (
   input  wire logic                        ref_clk_i,
   input  wire logic                        nrst_i,
   input  wire logic                        ce_i,
   input  wire fai_pkg::fai_reg_req_t       req_i,
   output logic      [fai_pkg::DATA_W-1:0]  rdata_o,
   input  wire fai_pkg::fai_faults_t        faults_i,
   input  wire logic [fai_pkg::GEN_W-1:0]   gen_event_i,
   input  wire logic [2:0]                  crc_fault_count_i,
   input  wire logic                        crc_limit8_i,
   input  wire logic                        nvm_loaded_i,
   output logic                             irq_o,
   output logic                             alarm_n_o
);

   typedef struct packed {
      logic [fai_pkg::DATA_W-1:0] alarm_mask;
      logic [fai_pkg::DATA_W-1:0] gen_mask;
      logic                       nvm_not_loaded;
      logic [fai_pkg::DATA_W-1:0] rdata;
   } fai_core_state_t;

   fai_core_state_t            state_reg;
   fai_core_state_t            state_next;
   logic [fai_pkg::DATA_W-1:0] alarm_raw;
   logic [fai_pkg::DATA_W-1:0] alarm_live;
   logic [fai_pkg::GEN_W-1:0]  gen_live;
   logic [fai_pkg::DATA_W-1:0] alarm_status;
   logic [fai_pkg::DATA_W-1:0] gen_status;
   logic [1:0]                 crc_view;
   logic                       general_irq_summary;
   logic                       alarm_irq_summary;
   logic                       osc_alarm;
   logic                       rd_alarm_status;

   function automatic logic [fai_pkg::DATA_W-1:0] mask_write(
      input logic [fai_pkg::DATA_W-1:0] wdata,
      input logic [fai_pkg::DATA_W-1:0] wr_bits,
      input logic [fai_pkg::DATA_W-1:0] rst_val
   );
      // Reserved bits keep their fixed reset pattern
      mask_write = (wdata & wr_bits) | (rst_val & ~wr_bits);
   endfunction

   // ****************************************************
   // Status capture
   // ****************************************************
   always_comb begin
      alarm_raw                           = '0;
      alarm_raw[fai_pkg::POS_SELF_DIAG]   = faults_i.self_diag_fault;   // [RL8]
      alarm_raw[fai_pkg::POS_OSC_START]   = faults_i.osc_start_fault;
      alarm_raw[fai_pkg::POS_NVM_CRC]     = faults_i.nvm_crc_error;     // [RL12]
      alarm_raw[fai_pkg::POS_FRAME_CRC]   = faults_i.frame_crc_fault;
      alarm_raw[fai_pkg::POS_WATCHDOG]    = faults_i.watchdog_fault;
      alarm_raw[fai_pkg::POS_REF_VOLT:0]  = {faults_i.ref_voltage_fault, faults_i.input1_range_fault,
                                             faults_i.input0_range_fault, faults_i.temp_channel_fault,
                                             faults_i.overtemp_error, faults_i.overtemp_warning};
   end

   assign rd_alarm_status = req_i.rd && (req_i.addr == fai_pkg::OFS_ALARM_STATUS);

   fai_status_latch #(
      .W      (fai_pkg::DATA_W),
      .STICKY (fai_pkg::STICKY_ALARM)
   ) u_alarm_latch (
      .ref_clk_i (ref_clk_i),
      .nrst_i    (nrst_i),
      .ce_i      (ce_i),
      .raw_i     (alarm_raw),
      .clear_i   (rd_alarm_status),   // [RL13]
      .status_o  (alarm_live)
   );

   fai_status_latch #(
      .W      (fai_pkg::GEN_W),
      .STICKY ('0)
   ) u_gen_latch (
      .ref_clk_i (ref_clk_i),
      .nrst_i    (nrst_i),
      .ce_i      (ce_i),
      .raw_i     (gen_event_i),
      .clear_i   (1'b0),
      .status_o  (gen_live)
   );

   // ****************************************************
   // Summaries and outputs
   // ****************************************************
   // A limit of eight drops the count's low bit to fit two bits [RL10]
   assign crc_view = crc_limit8_i ? crc_fault_count_i[2:1] : crc_fault_count_i[1:0];

   // Masks only gate here; the status words stay untouched [RL2] [RL15]
   assign general_irq_summary = |(gen_live & ~state_reg.gen_mask[fai_pkg::GEN_W-1:0]);   // [RL5] [RL7]
   assign alarm_irq_summary   = |(alarm_live & fai_pkg::IRQ_ALARM_BITS
                                  & ~state_reg.alarm_mask);                              // [RL1] [RL12] [RL14]
   assign osc_alarm           = alarm_live[fai_pkg::POS_OSC_START]
                                & ~state_reg.alarm_mask[fai_pkg::POS_OSC_START];         // [RL9]

   always_comb begin
      alarm_status                                                 = alarm_live;
      alarm_status[fai_pkg::POS_GENERAL_IRQ_SUMMARY]                           = general_irq_summary;  // [RL7]
      alarm_status[fai_pkg::POS_CRC_FAULT_COUNT_HI:fai_pkg::POS_CRC_FAULT_COUNT_LO] = crc_view;            // [RL10]
      alarm_status[fai_pkg::POS_NVM_NL]                            = state_reg.nvm_not_loaded;
      gen_status                                                   = '0;
      gen_status[fai_pkg::GEN_W-1:0]                               = gen_live;
      gen_status[fai_pkg::POS_ALARM_IRQ]                           = alarm_irq_summary;    // [RL14]
   end

   // The unmasked oscillator flag and the nvm-not-loaded flag hold the alarm but stay out of the interrupt [RL9] [RL11]
   assign irq_o     = alarm_irq_summary | general_irq_summary;
   assign alarm_n_o = ~(alarm_irq_summary | osc_alarm | state_reg.nvm_not_loaded);
   assign rdata_o   = state_reg.rdata;

   // ****************************************************
   // Registers
   // ****************************************************
   always_comb begin
      state_next = state_reg;
      if (nvm_loaded_i) begin
         state_next.nvm_not_loaded = 1'b0;   // [RL11]
      end
      if (req_i.wr) begin
         if (req_i.addr == fai_pkg::OFS_ALARM_MASK) begin
            state_next.alarm_mask = mask_write(req_i.wdata, fai_pkg::WR_ALARM_MASK,
                                               fai_pkg::RST_ALARM_MASK);   // [RL15]
         end else if (req_i.addr == fai_pkg::OFS_GEN_MASK) begin
            state_next.gen_mask = mask_write(req_i.wdata, fai_pkg::WR_GEN_MASK, fai_pkg::RST_GEN_MASK);
         end
      end
      if (req_i.rd) begin
         if (req_i.addr == fai_pkg::OFS_ALARM_MASK) begin
            state_next.rdata = state_reg.alarm_mask;
         end else if (req_i.addr == fai_pkg::OFS_GEN_MASK) begin
            state_next.rdata = state_reg.gen_mask;
         end else if (req_i.addr == fai_pkg::OFS_ALARM_STATUS) begin
            state_next.rdata = alarm_status;
         end else if (req_i.addr == fai_pkg::OFS_GEN_STATUS) begin
            state_next.rdata = gen_status;
         end else begin
            state_next.rdata = '0;
         end
      end
   end

   always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         state_reg.alarm_mask     <= fai_pkg::RST_ALARM_MASK;   // [RL1] [RL3] [RL4]
         state_reg.gen_mask       <= fai_pkg::RST_GEN_MASK;     // [RL5] [RL6]
         state_reg.nvm_not_loaded <= fai_pkg::RST_ALARM_STATUS[fai_pkg::POS_NVM_NL];   // [RL11]
         state_reg.rdata          <= '0;
      end else if (ce_i) begin
         state_reg <= state_next;
      end
   end

   // ****************************************************
   // Checks
   // ****************************************************
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!nrst_i);

   chk_sd_unmasked_irq: assert property ( // [RL1]
      alarm_live[13] && !state_reg.alarm_mask[13] |-> irq_o && !alarm_n_o)
      else $error("unmasked self-diag fault did not raise irq and alarm");
   chk_status_unmasked: assert property ( // [RL2]
      !irq_o |-> (alarm_live & ~state_reg.alarm_mask & 16'h21ff) == 16'h0000)
      else $error("live unmasked fault without irq");
   chk_osc_ref_reset: assert property ( // [RL3]
      !$past(nrst_i) |-> !state_reg.alarm_mask[12] && !state_reg.alarm_mask[5])
      else $error("osc or ref mask not clear after reset");
   chk_alarm_mask_reset: assert property ( // [RL4]
      !$past(nrst_i) |-> state_reg.alarm_mask == 16'hefdf)
      else $error("alarm mask reset value wrong");
   chk_gen_mask_reset: assert property ( // [RL6]
      !$past(nrst_i) |-> state_reg.gen_mask == 16'hffff)
      else $error("general mask reset value wrong");
   chk_slew_irq: assert property ( // [RL5]
      gen_live[7] && !state_reg.gen_mask[7] |-> irq_o)
      else $error("unmasked slew-idle did not raise irq");
   chk_gen_summary_read: assert property ( // [RL7]
      ce_i && rd_alarm_status |=> rdata_o[15] == $past(general_irq_summary))
      else $error("general summary read back wrong");
   chk_osc_holds_alarm: assert property ( // [RL9]
      osc_alarm |-> !alarm_n_o)
      else $error("oscillator fault did not hold alarm");
   chk_nvm_alarm: assert property ( // [RL11]
      ce_i && nvm_loaded_i |=> (!state_reg.nvm_not_loaded) [*2])
      else $error("nvm loaded flag did not clear");
   chk_nvm_holds_alarm: assert property ( // [RL11]
      state_reg.nvm_not_loaded |-> !alarm_n_o && alarm_status[9])
      else $error("nvm not loaded did not hold alarm");
   chk_sticky_hold: assert property ( // [RL13]
      alarm_live[7] && !rd_alarm_status |=> alarm_live[7])
      else $error("latched frame crc fault lost without read");
   chk_crc_view: assert property ( // [RL10]
      crc_limit8_i |-> alarm_status[11:10] == crc_fault_count_i[2:1])
      else $error("crc count view wrong for limit eight");
   chk_mask_write_next: assert property ( // [RL15]
      ce_i && req_i.wr && req_i.addr == fai_pkg::OFS_ALARM_MASK
      |=> state_reg.alarm_mask == (($past(req_i.wdata) & 16'h31ff) | 16'hce00))
      else $error("alarm mask write did not take effect next cycle");

   cov_irq_rise:    cover property ($rose(irq_o));
   cov_alarm_fall:  cover property ($fell(alarm_n_o));
   cov_read_clear:  cover property (alarm_live[6] && rd_alarm_status ##1 !alarm_live[6]);
   cov_nvm_loaded:  cover property ($fell(state_reg.nvm_not_loaded));

endmodule

// ---- rtl/fai_pkg.sv ----
/*
   Package for the fault and event interrupt masking block: register offsets,
   field positions, reset values and the writable-bit layouts of the masks.
   Assumes a 16-bit register port with a byte-wide word address.
*/
package fai_pkg;

   // ****************************************************
   // Register port geometry
   // ****************************************************
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 16;
   localparam int unsigned GEN_W  = 8;

   localparam logic [ADDR_W-1:0] OFS_ALARM_MASK   = 8'h1d;
   localparam logic [ADDR_W-1:0] OFS_GEN_MASK     = 8'h1e;
   localparam logic [ADDR_W-1:0] OFS_ALARM_STATUS = 8'h20;
   localparam logic [ADDR_W-1:0] OFS_GEN_STATUS   = 8'h21;

   // ****************************************************
   // Reset values and writable bits
   // ****************************************************
   localparam logic [DATA_W-1:0] RST_ALARM_MASK   = 16'hefdf;
   localparam logic [DATA_W-1:0] RST_GEN_MASK     = 16'hffff;
   localparam logic [DATA_W-1:0] RST_ALARM_STATUS = 16'h0200;
   localparam logic [DATA_W-1:0] WR_ALARM_MASK    = 16'h31ff;
   localparam logic [DATA_W-1:0] WR_GEN_MASK      = 16'h00cf;
   // Bits that take part in the alarm summary and the interrupt
   localparam logic [DATA_W-1:0] IRQ_ALARM_BITS   = 16'h21ff;
   // Latched bits, cleared by a read of the alarm status
   localparam logic [DATA_W-1:0] STICKY_ALARM     = 16'h01c0;

   // ****************************************************
   // Field positions
   // ****************************************************
   localparam int unsigned POS_GENERAL_IRQ_SUMMARY     = 15;
   localparam int unsigned POS_ALARM_IRQ   = 15;
   localparam int unsigned POS_SELF_DIAG   = 13;
   localparam int unsigned POS_OSC_START   = 12;
   localparam int unsigned POS_CRC_FAULT_COUNT_HI  = 11;
   localparam int unsigned POS_CRC_FAULT_COUNT_LO  = 10;
   localparam int unsigned POS_NVM_NL      = 9;
   localparam int unsigned POS_NVM_CRC     = 8;
   localparam int unsigned POS_FRAME_CRC   = 7;
   localparam int unsigned POS_WATCHDOG    = 6;
   localparam int unsigned POS_REF_VOLT    = 5;
   localparam int unsigned POS_SLEW_IDLE   = 7;

   // ****************************************************
   // Carriers
   // ****************************************************
   typedef struct packed {
      logic              self_diag_fault;
      logic              osc_start_fault;
      logic              nvm_crc_error;
      logic              frame_crc_fault;
      logic              watchdog_fault;
      logic              ref_voltage_fault;
      logic              input1_range_fault;
      logic              input0_range_fault;
      logic              temp_channel_fault;
      logic              overtemp_error;
      logic              overtemp_warning;
   } fai_faults_t;

   typedef struct packed {
      logic              wr;
      logic              rd;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } fai_reg_req_t;

endpackage

// ---- rtl/fai_status_latch.sv ----
/*
   Status capture: two-flop synchronisers on raw condition levels, with
   optional sticky latching per bit and clear-on-read for the sticky bits.
   Assumes the clear request comes from logic on the same clock.
*/
module fai_status_latch #(
   parameter int unsigned     W      = 16,
   parameter logic [W-1:0]    STICKY = '0
) (
   input  wire logic          ref_clk_i,
   input  wire logic          nrst_i,
   input  wire logic          ce_i,
   input  wire logic [W-1:0]  raw_i,
   input  wire logic          clear_i,
   output logic      [W-1:0]  status_o
);

   // Refused at elaboration: the sticky pattern is carried as a 32-bit constant at most
   if (W < 1 || W > 32) begin : g_width_check
      $error("status latch width out of range");
   end

   typedef struct packed {
      logic [W-1:0] sync1;
      logic [W-1:0] sync2;
      logic [W-1:0] held;
   } fai_latch_state_t;

   fai_latch_state_t state_reg;
   fai_latch_state_t state_next;

   // ****************************************************
   // Capture
   // ****************************************************
   always_comb begin
      state_next       = state_reg;
      state_next.sync1 = raw_i;
      state_next.sync2 = state_reg.sync1;
      // A live condition re-sets a bit in the very cycle of its clear [RL13]
      state_next.held  = ((state_reg.held & ~{W{clear_i}}) | state_reg.sync2) & STICKY;
   end

   always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         state_reg <= '0;
      end else if (ce_i) begin
         state_reg <= state_next;
      end
   end

   // Status follows the condition whatever the masks say [RL2]
   assign status_o = state_reg.held | state_reg.sync2;

endmodule

// ---- dv/fai_tb.sv ----
/*
   Self-checking bench for the fault and event masking core: register reads
   and writes on the block's own request port, fault and event levels driven.
   Assumes fai_pkg is compiled first and the core's checks sit in its body.
*/
`define CHK(what, exp, got) begin comparisons++; if ((got) !== (exp)) begin failures++; \
   $display("ERROR %s expected %h seen %h", what, exp, got); end end

module testbench;
   timeunit 1ns;
   timeprecision 1ps;

   // ****************************************************
   // Stimulus and design
   // ****************************************************
   logic                    ref_clk_i = 1'b0;
   logic                    nrst_i    = 1'b0;
   logic                    ce_i      = 1'b1;
   fai_pkg::fai_reg_req_t   req       = '0;
   fai_pkg::fai_faults_t    flt       = '0;
   logic [7:0]              gen       = 8'h00;
   logic [2:0]              cnt       = 3'h0;
   logic                    lim8      = 1'b0;
   logic                    nvm_ld    = 1'b0;
   logic [15:0]             rdata;
   logic                    irq;
   logic                    alarm_n;
   logic [15:0]             b;
   int                      failures;
   int                      comparisons;
   int                      cycles;

   always #50 ref_clk_i = ~ref_clk_i;

   fai_irq_core i_dut (
      .ref_clk_i         (ref_clk_i),
      .nrst_i            (nrst_i),
      .ce_i              (ce_i),
      .req_i             (req),
      .rdata_o           (rdata),
      .faults_i          (flt),
      .gen_event_i       (gen),
      .crc_fault_count_i (cnt),
      .crc_limit8_i      (lim8),
      .nvm_loaded_i      (nvm_ld),
      .irq_o             (irq),
      .alarm_n_o         (alarm_n)
   );

   // ****************************************************
   // Access tasks
   // ****************************************************
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(negedge ref_clk_i);
      req.wr    = 1'b1;
      req.addr  = a;
      req.wdata = d;
      @(negedge ref_clk_i);
      req.wr    = 1'b0;
   endtask

   // Read data is registered at the taking edge, so it is looked at one half cycle later
   task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
      @(negedge ref_clk_i);
      req.rd   = 1'b1;
      req.addr = a;
      @(negedge ref_clk_i);
      req.rd   = 1'b0;
      `CHK("rdata", exp, rdata)
   endtask

   // Two synchroniser flops lie between a level and its status bit
   task automatic settle();
      repeat (3) @(negedge ref_clk_i);
   endtask

   task automatic final_report();
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // Whole run needs well under a thousand cycles
   always @(posedge ref_clk_i) begin
      cycles++;
      if (cycles == 5000) begin
         failures++;
         final_report();
      end
   end

   // ****************************************************
   // Tests
   // ****************************************************
   initial begin
      repeat (8) @(negedge ref_clk_i);
      nrst_i = 1'b1;
      `CHK("irq", 1'b0, irq)
      `CHK("alarm_n", 1'b0, alarm_n)
      rd_chk(8'h1d, 16'hefdf);
      rd_chk(8'h1e, 16'hffff);
      rd_chk(8'h20, 16'h0200);
      rd_chk(8'h33, 16'h0000);
      @(negedge ref_clk_i) nvm_ld = 1'b1;
      @(negedge ref_clk_i) nvm_ld = 1'b0;
      settle();
      rd_chk(8'h20, 16'h0000);
      `CHK("alarm_n", 1'b1, alarm_n)
      flt.self_diag_fault = 1'b1;
      settle();
      `CHK("irq", 1'b0, irq)
      rd_chk(8'h20, 16'h2000);
      wr(8'h1d, 16'hcfdf);
      `CHK("irq", 1'b1, irq)
      `CHK("alarm_n", 1'b0, alarm_n)
      rd_chk(8'h20, 16'h2000);
      wr(8'h1d, 16'hefdf);
      flt.self_diag_fault = 1'b0;
      flt.osc_start_fault = 1'b1;
      settle();
      `CHK("alarm_n", 1'b0, alarm_n)
      `CHK("irq", 1'b0, irq)
      rd_chk(8'h20, 16'h1000);
      flt.osc_start_fault = 1'b0;
      flt.ref_voltage_fault = 1'b1;
      settle();
      `CHK("irq", 1'b1, irq)
      rd_chk(8'h21, 16'h8000);
      flt.ref_voltage_fault = 1'b0;
      // Each remaining alarm source: silent while masked, loud when unmasked
      for (int i = 0; i < 9; i++) begin
         if (i == 5) continue;
         b = 16'h0001 << i;
         flt[i] = 1'b1;
         settle();
         `CHK("irq", 1'b0, irq)
         wr(8'h1d, 16'hefdf & ~b);
         `CHK("irq", 1'b1, irq)
         flt[i] = 1'b0;
         settle();
         rd_chk(8'h20, (i >= 6) ? b : 16'h0000);
         rd_chk(8'h20, 16'h0000);
         wr(8'h1d, 16'hefdf);
      end
      flt.watchdog_fault = 1'b1;
      settle();
      rd_chk(8'h20, 16'h0040);
      rd_chk(8'h20, 16'h0040);
      flt.watchdog_fault = 1'b0;
      settle();
      rd_chk(8'h20, 16'h0040);
      cnt = 3'h6;
      rd_chk(8'h20, 16'h0800);
      lim8 = 1'b1;
      rd_chk(8'h20, 16'h0c00);
      cnt = 3'h0;
      gen[7] = 1'b1;
      settle();
      `CHK("irq", 1'b0, irq)
      rd_chk(8'h20, 16'h0000);
      rd_chk(8'h21, 16'h0080);
      wr(8'h1e, 16'hff7f);
      `CHK("irq", 1'b1, irq)
      rd_chk(8'h20, 16'h8000);
      wr(8'h1e, 16'hffff);
      gen[7] = 1'b0;
      foreach (b[i]) begin
         if (i > 6 || i == 5 || i == 4) continue;
         gen[i] = 1'b1;
         settle();
         `CHK("irq", 1'b0, irq)
         wr(8'h1e, 16'hffff & ~(16'h0001 << i));
         `CHK("irq", 1'b1, irq)
         wr(8'h1e, 16'hffff);
         gen[i] = 1'b0;
      end
      // Reserved mask bits stay fixed whatever is written
      wr(8'h1d, 16'h0000);
      rd_chk(8'h1d, 16'hce00);
      wr(8'h1e, 16'h0000);
      rd_chk(8'h1e, 16'hff30);
      @(negedge ref_clk_i) ce_i = 1'b0;
      wr(8'h1d, 16'hefdf);
      @(negedge ref_clk_i) ce_i = 1'b1;
      rd_chk(8'h1d, 16'hce00);
      final_report();
   end
endmodule
